/* File: bench/cise_exec_test.sv */
// self-checking bench for the instruction subset executor
`timescale 1ns/10ps
module cise_exec_test;
  import cise_pkg::*;

  logic              clock_in;
  logic              rst_n_in;
  cise_bus_t         bus_q;
  logic [PC_W-1:0]   stack_q;
  logic [DATA_W-1:0] rd_data_out;
  logic              stack_pop_out;
  logic [PC_W-1:0]   program_counter_out;
  logic              refetch_out;
  logic              sleep_out;
  logic              busy_out;
  int                miscompares;
  int                tests_run;
  logic [7:0]        m_acc;
  logic [7:0]        m_file;
  logic [4:0]        m_st;
  logic [PC_W-1:0]   m_pc;

  cise_exec DUT (
    .clock_in            (clock_in),
    .rst_n_in            (rst_n_in),
    .bus_in              (bus_q),
    .rd_data_out         (rd_data_out),
    .stack_top_value_in  (stack_q),
    .stack_pop_out       (stack_pop_out),
    .program_counter_out (program_counter_out),
    .refetch_out         (refetch_out),
    .sleep_out           (sleep_out),
    .busy_out            (busy_out)
  );

  initial clock_in = 1'b0;
  always #50 clock_in = ~clock_in;

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : tally_and_finish

  task automatic bus_wr(input logic [ADDR_W-1:0] a, input logic [15:0] d);
    @(posedge clock_in);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    bus_q <= '0;
  endtask : bus_wr

  task automatic bus_rd(input logic [ADDR_W-1:0] a, output logic [15:0] d);
    @(posedge clock_in);
    bus_q <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge clock_in);
    bus_q <= '0;
    @(negedge clock_in);
    d = rd_data_out;
  endtask : bus_rd

  // counts busy cycles of one instruction, bounded
  task automatic wait_idle(output int n);
    n = 0;
    for (int k = 0; k < 10; k++) begin
      @(negedge clock_in);
      if (busy_out !== 1'b1) break;
      n++;
    end
  endtask : wait_idle

  task automatic check_regs();
    logic [15:0] v;
    bus_rd(REG_ACC, v);
    check("acc", v, {8'h00, m_acc});
    bus_rd(REG_FDATA, v);
    check("file", v, {8'h00, m_file});
    bus_rd(REG_STATUS, v);
    check("status", v, {11'h000, m_st});
    bus_rd(REG_PC, v);
    check("pc", v, {1'b0, m_pc});
  endtask : check_regs

  task automatic exec_one(input cise_op_t op, input logic dst, input logic [6:0] fa,
                          input logic [7:0] fv, input logic [7:0] av);
    cise_instr_t ins;
    logic [7:0]  res;
    int          n;
    bus_wr(REG_FADDR, {9'h000, fa});
    bus_wr(REG_FDATA, {8'h00, fv});
    bus_wr(REG_ACC, {8'h00, av});
    m_acc = av;
    m_file = fv;
    case (op)
      OP_ROTL: begin
        res = {fv[6:0], m_st[SB_C]};
        m_st[SB_C] = fv[7];
      end
      OP_ROTR: begin
        res = {m_st[SB_C], fv[7:1]};
        m_st[SB_C] = fv[0];
      end
      default: begin
        res = fv - av;
        m_st[SB_C] = (av <= fv);
        m_st[SB_NC] = (av[3:0] <= fv[3:0]);
        m_st[SB_Z] = (res == 8'h00);
      end
    endcase
    if (dst) m_file = res;
    else m_acc = res;
    ins = '{pad: 5'h00, op: op, dest: dst, faddr: fa};
    bus_wr(REG_INSTR, ins);
    wait_idle(n);
    check("busy_cycles", 16'(n), 16'h0001);
    m_pc = m_pc + PC_STEP;
    check_regs();
  endtask : exec_one

  initial begin
    logic [15:0] v;
    cise_op_t    op;
    int          seed_val;
    int          n;
    rst_n_in = 1'b0;
    bus_q = '0;
    stack_q = '0;
    miscompares = 0;
    tests_run = 0;
    m_acc = ACC_RST;
    m_st = STATUS_RST;
    m_pc = PC_RST;
    seed_val = $urandom(30351);
    repeat (8) @(posedge clock_in);
    rst_n_in <= 1'b1;
    bus_rd(REG_STATUS, v);
    check("status_reset", v, 16'h0018);
    bus_rd(4'hB, v);
    check("unmapped", v, 16'h0000);
    // rotates and subtract with both destinations, file address at both ends first
    for (int i = 0; i < 42; i++) begin
      op = (i % 3 == 0) ? OP_ROTL : (i % 3 == 1) ? OP_ROTR : OP_SUB;
      exec_one(op, 1'((i / 3) % 2), (i < 6) ? 7'h00 : (i < 12) ? 7'h7F : 7'($urandom_range(0, 127)),
               8'($urandom_range(0, 255)), (i == 5) ? 8'h00 : 8'($urandom_range(0, 255)));
    end
    exec_one(OP_SUB, 1'b0, 7'h11, 8'h3C, 8'h3C);
    exec_one(OP_SUB, 1'b1, 7'h12, 8'h20, 8'h21);
    // return with a write landing in its refetch cycle, which must be dropped
    stack_q <= 15'($urandom_range(0, 32767));
    bus_wr(REG_INSTR, 16'h0100);
    @(posedge clock_in);
    bus_q <= '{wr: 1'b1, rd: 1'b0, addr: REG_ACC, wdata: 16'h00A5};
    @(negedge clock_in);
    check("pop", 16'(stack_pop_out), 16'h0001);
    check("refetch", 16'(refetch_out), 16'h0001);
    check("pc_out", 16'(program_counter_out), {1'b0, stack_q});
    @(posedge clock_in);
    bus_q <= '0;
    @(negedge clock_in);
    check("pop_end", 16'(stack_pop_out), 16'h0000);
    check("busy_end", 16'(busy_out), 16'h0000);
    m_pc = stack_q;
    check_regs();
    // sleep after the watchdog has run for a while
    bus_rd(REG_WDOG, v);
    check("wdog_running", 16'(v[15:8] != 8'h00), 16'h0001);
    bus_wr(REG_INSTR, 16'h0400);
    @(posedge clock_in);
    bus_rd(REG_WDOG, v);
    check("wdog_cleared", {8'h00, v[15:8]}, 16'h0000);
    check("prescaler_cleared", 16'(v[7:0] < 8'h03), 16'h0001);
    check("sleep_out", 16'(sleep_out), 16'h0001);
    m_st[SB_PWD] = 1'b0;
    m_st[SB_TMO] = 1'b1;
    m_pc = m_pc + PC_STEP;
    check_regs();
    // a no-op ends the sleep indication and leaves every flag alone
    bus_wr(REG_INSTR, 16'h0000);
    wait_idle(n);
    check("nop_cycles", 16'(n), 16'h0001);
    check("sleep_clear", 16'(sleep_out), 16'h0000);
    m_pc = m_pc + PC_STEP;
    check_regs();
    tally_and_finish();
  end

  initial begin
    #(6000 * 100);
    miscompares++;
    tally_and_finish();
  end

endmodule : cise_exec_test

/* File: verilog/cise_exec.sv */
// executor for return, rotate through carry, sleep and subtract-from-file
`timescale 1ns/10ps
module cise_exec #(
  parameter int PRE_W = 8,
  parameter int WDT_W = 8
) (
  // clock and reset
  input  wire logic                      clock_in,
  input  wire logic                      rst_n_in,
  // register port
  input  wire cise_pkg::cise_bus_t       bus_in,
  output logic [cise_pkg::DATA_W-1:0]    rd_data_out,
  // hardware stack
  input  wire logic [cise_pkg::PC_W-1:0] stack_top_value_in,
  output logic                           stack_pop_out,
  // core state
  output logic [cise_pkg::PC_W-1:0]      program_counter_out,
  output logic                           refetch_out,
  output logic                           sleep_out,
  output logic                           busy_out
);
  import cise_pkg::*;

  cise_state_t       state_q;
  cise_state_t       state_d;
  cise_instr_t       instr_q;
  logic [BYTE_W-1:0] acc_q;
  logic [STAT_W-1:0] status_q;
  logic [PC_W-1:0]   pc_q;
  logic [FILE_AW-1:0] faddr_q;
  logic [PRE_W-1:0]  presc_q;
  logic [WDT_W-1:0]  watchdog_counter_q;
  logic [BYTE_W-1:0] mem_q;

  // bus decode
  wire idle      = (state_q == ST_IDLE);
  wire wr_ok     = bus_in.wr & idle;
  wire wr_instr  = wr_ok & (bus_in.addr == REG_INSTR);
  wire wr_acc    = wr_ok & (bus_in.addr == REG_ACC);
  wire wr_status = wr_ok & (bus_in.addr == REG_STATUS);
  wire wr_pc     = wr_ok & (bus_in.addr == REG_PC);
  wire wr_faddr  = wr_ok & (bus_in.addr == REG_FADDR);
  wire wr_fdata  = wr_ok & (bus_in.addr == REG_FDATA);

  wire cise_instr_t wr_instr_val = cise_instr_t'(bus_in.wdata);
  wire [FILE_AW-1:0] faddr_d = wr_faddr ? bus_in.wdata[FILE_AW-1:0] : faddr_q;

  // execute-cycle decode
  wire exec      = (state_q == ST_EXEC);
  wire do_ret    = exec & (instr_q.op == OP_RETURN);
  wire do_rotl   = exec & (instr_q.op == OP_ROTL);
  wire do_rotr   = exec & (instr_q.op == OP_ROTR);
  wire do_sleep  = exec & (instr_q.op == OP_SLEEP);
  wire do_sub    = exec & (instr_q.op == OP_SUB);
  wire do_alu    = do_rotl | do_rotr | do_sub;
  wire old_c     = status_q[SB_C];

  function automatic cise_alu_t alu_eval(input cise_op_t op, input logic [BYTE_W-1:0] f,
                                         input logic [BYTE_W-1:0] w, input logic c);
    cise_alu_t r;
    r = '{res: f, c: c, nc: 1'b0, z: 1'b0};
    unique case (op)
      OP_ROTL: begin
        r.res = {f[BYTE_W-2:0], c};
        r.c   = f[BYTE_W-1];
      end
      OP_ROTR: begin
        r.res = {c, f[BYTE_W-1:1]};
        r.c   = f[0];
      end
      OP_SUB: begin
        r.res = f - w;
        r.c   = (w <= f);
        r.nc  = (w[3:0] <= f[3:0]);
        r.z   = (r.res == '0);
      end
      default: begin
        r.res = f;
      end
    endcase
    return r;
  endfunction : alu_eval

  wire cise_alu_t alu = alu_eval(instr_q.op, mem_q, acc_q, old_c);

  // destination steering shared by rotates and subtract
  wire to_file   = do_alu & instr_q.dest;
  wire to_acc    = do_alu & ~instr_q.dest;

  // memory port: execution owns it while busy
  wire               mem_we    = to_file | wr_fdata;
  wire [FILE_AW-1:0] mem_waddr = to_file ? instr_q.faddr : faddr_q;
  wire [BYTE_W-1:0]  mem_wdata = to_file ? alu.res : bus_in.wdata[BYTE_W-1:0];
  wire [FILE_AW-1:0] mem_raddr = wr_instr ? wr_instr_val.faddr : faddr_d;

  cise_file_mem #(
    .WIDTH (BYTE_W),
    .AW    (FILE_AW)
  ) u_file_mem (
    .clock_in  (clock_in),
    .we_in     (mem_we),
    .waddr_in  (mem_waddr),
    .wdata_in  (mem_wdata),
    .raddr_in  (mem_raddr),
    .rdata_out (mem_q)
  );

  // sequencer
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      ST_IDLE:    if (wr_instr) state_d = ST_EXEC;
      ST_EXEC:    state_d = do_ret ? ST_REFETCH : ST_IDLE;
      ST_REFETCH: state_d = ST_IDLE;
      default:    state_d = ST_IDLE;
    endcase
  end

  // status next value: execution is applied after a software write
  logic [STAT_W-1:0] status_d;
  always_comb begin
    status_d = wr_status ? bus_in.wdata[STAT_W-1:0] : status_q;
    if (do_rotl || do_rotr) begin
      status_d[SB_C] = alu.c;
    end
    if (do_sub) begin
      status_d[SB_C]  = alu.c;
      status_d[SB_NC] = alu.nc;
      status_d[SB_Z]  = alu.z;
    end
    if (do_sleep) begin
      status_d[SB_PWD] = 1'b0;
      status_d[SB_TMO] = 1'b1;
    end
  end

  wire [PC_W-1:0] pc_d = do_ret ? stack_top_value_in :
                         (exec ? pc_q + PC_STEP : (wr_pc ? bus_in.wdata[PC_W-1:0] : pc_q));

  wire presc_wrap = &presc_q;

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      state_q  <= ST_IDLE;
      instr_q  <= '0;
      acc_q    <= ACC_RST;
      status_q <= STATUS_RST;
      pc_q     <= PC_RST;
      faddr_q  <= '0;
    end else begin
      state_q  <= state_d;
      status_q <= status_d;
      pc_q     <= pc_d;
      faddr_q  <= faddr_d;
      if (wr_instr) begin
        instr_q <= wr_instr_val;
      end
      if (to_acc) begin
        acc_q <= alu.res;
      end else if (wr_acc) begin
        acc_q <= bus_in.wdata[BYTE_W-1:0];
      end
    end
  end

  // watchdog prescaler and counter
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || do_sleep) begin
      presc_q            <= '0;
      watchdog_counter_q <= '0;
    end else begin
      presc_q <= presc_q + 1'b1;
      if (presc_wrap) begin
        watchdog_counter_q <= watchdog_counter_q + 1'b1;
      end
    end
  end

  // read mux
  logic [DATA_W-1:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    unique case (bus_in.addr)
      REG_INSTR:  rd_mux = instr_q;
      REG_ACC:    rd_mux[BYTE_W-1:0] = acc_q;
      REG_STATUS: rd_mux[STAT_W-1:0] = status_q;
      REG_PC:     rd_mux[PC_W-1:0] = pc_q;
      REG_FADDR:  rd_mux[FILE_AW-1:0] = faddr_q;
      REG_FDATA:  rd_mux[BYTE_W-1:0] = mem_q;
      REG_WDOG:   rd_mux = DATA_W'({watchdog_counter_q, presc_q});
      REG_STATE:  rd_mux = DATA_W'({sleep_out, state_q});
      default:    rd_mux = '0;
    endcase
  end

  // outputs, all registered
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      rd_data_out         <= '0;
      stack_pop_out       <= 1'b0;
      program_counter_out <= PC_RST;
      refetch_out         <= 1'b0;
      sleep_out           <= 1'b0;
      busy_out            <= 1'b0;
    end else begin
      rd_data_out         <= bus_in.rd ? rd_mux : '0;
      stack_pop_out       <= do_ret;
      program_counter_out <= pc_d;
      refetch_out         <= (state_d == ST_REFETCH);
      busy_out            <= (state_d != ST_IDLE);
      if (do_sleep) begin
        sleep_out <= 1'b1;
      end else if (wr_instr) begin
        sleep_out <= 1'b0;
      end
    end
  end

  // checks
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_n_in);

  chk_ret_pc_load: assert property (do_ret |=> (pc_q == $past(stack_top_value_in)) && stack_pop_out)
    else $error("return did not load popped stack value");
  chk_ret_flags_kept: assert property (do_ret |=> status_q == $past(status_q))
    else $error("return altered status");
  chk_ret_two_cycles: assert property (do_ret |=> state_q == ST_REFETCH && refetch_out ##1 state_q == ST_IDLE)
    else $error("return did not take two cycles with refetch");
  chk_rotl_to_acc: assert property (do_rotl && !instr_q.dest |=>
      acc_q == {$past(mem_q[BYTE_W-2:0]), $past(old_c)} && status_q[SB_C] == $past(mem_q[BYTE_W-1]))
    else $error("rotate left result wrong");
  chk_rotr_to_file: assert property (do_rotr && instr_q.dest |->
      mem_we && mem_waddr == instr_q.faddr && mem_wdata == {old_c, mem_q[BYTE_W-1:1]})
    else $error("rotate right file write wrong");
  chk_rot_dest_sel: assert property ((do_rotl || do_rotr) && !instr_q.dest |-> !mem_we ##1 acc_q == $past(alu.res))
    else $error("rotate destination steering wrong");
  chk_sleep_wdog_clr: assert property (do_sleep |=> presc_q == '0 && watchdog_counter_q == '0)
    else $error("sleep did not clear watchdog");
  chk_sleep_pwd_clr: assert property (do_sleep |=> !status_q[SB_PWD] && sleep_out)
    else $error("sleep did not clear power-down flag");
  chk_sleep_tmo_set: assert property (do_sleep |=> status_q[SB_TMO])
    else $error("sleep did not set time-out flag");
  chk_sub_file_val: assert property (do_sub && instr_q.dest |-> mem_we && mem_wdata == BYTE_W'(mem_q - acc_q))
    else $error("subtract file result wrong");
  chk_sub_acc_val: assert property (do_sub && !instr_q.dest |=> acc_q == BYTE_W'($past(mem_q) - $past(acc_q)))
    else $error("subtract accumulator result wrong");
  chk_sub_flag_set: assert property (do_sub |=> status_q[SB_C] == ($past(acc_q) <= $past(mem_q)) &&
      status_q[SB_NC] == ($past(acc_q[3:0]) <= $past(mem_q[3:0])) &&
      status_q[SB_Z] == (BYTE_W'($past(mem_q) - $past(acc_q)) == '0))
    else $error("subtract flags wrong");
  chk_rot_one_cycle: assert property ((do_rotl || do_rotr) |=> idle &&
      status_q[STAT_W-1:SB_NC] == $past(status_q[STAT_W-1:SB_NC]))
    else $error("rotate took extra cycle or touched other flags");

  cov_return_seq: cover property (do_ret ##1 refetch_out ##1 idle);
  cov_sub_borrow: cover property (do_sub && (acc_q > mem_q));
  cov_rotl_file: cover property (do_rotl && instr_q.dest);
  cov_sleep_run: cover property (do_sleep ##1 sleep_out);

endmodule : cise_exec

/* File: verilog/cise_file_mem.sv */
// file register memory with registered read data and write-through
`timescale 1ns/10ps
module cise_file_mem #(
  parameter int WIDTH = 8,
  parameter int AW    = 7
) (
  // clock
  input  wire logic             clock_in,
  // write port
  input  wire logic             we_in,
  input  wire logic [AW-1:0]    waddr_in,
  input  wire logic [WIDTH-1:0] wdata_in,
  // read port
  input  wire logic [AW-1:0]    raddr_in,
  output logic      [WIDTH-1:0] rdata_out
);

  logic [WIDTH-1:0] mem_q [0:(1<<AW)-1];

  always_ff @(posedge clock_in) begin
    if (we_in) begin
      mem_q[waddr_in] <= wdata_in;
    end
  end

  // a write to the address being read is passed straight through
  always_ff @(posedge clock_in) begin
    if (we_in && (waddr_in == raddr_in)) begin
      rdata_out <= wdata_in;
    end else begin
      rdata_out <= mem_q[raddr_in];
    end
  end

endmodule : cise_file_mem

/* File: verilog/cise_pkg.sv */
// constants, types and field layout shared by the instruction subset executor
// What this block does
// - return pops the stack, loads the popped top value into the program counter, flags untouched
// - return takes two cycles, the second refetches from the restored counter
// - rotate left moves old carry into bit 0, old bit 7 into carry
// - rotate destination bit 0 writes accumulator, 1 writes the file register
// - rotate right moves old carry into bit 7, old bit 0 into carry
// - sleep clears the watchdog counter and its prescaler to zero
// - sleep clears the power-down flag to 0
// - sleep sets the time-out flag to 1
// - subtract computes file register minus accumulator in two's complement
// - subtract destination bit 0 writes accumulator, 1 writes the file register
package cise_pkg;

  localparam int DATA_W  = 16;
  localparam int ADDR_W  = 4;
  localparam int FILE_AW = 7;
  localparam int BYTE_W  = 8;
  localparam int PC_W    = 15;
  localparam int STAT_W  = 5;

  // register offsets on the plain register port
  localparam logic [ADDR_W-1:0] REG_INSTR  = 4'h0;
  localparam logic [ADDR_W-1:0] REG_ACC    = 4'h1;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h2;
  localparam logic [ADDR_W-1:0] REG_PC     = 4'h3;
  localparam logic [ADDR_W-1:0] REG_FADDR  = 4'h4;
  localparam logic [ADDR_W-1:0] REG_FDATA  = 4'h5;
  localparam logic [ADDR_W-1:0] REG_WDOG   = 4'h6;
  localparam logic [ADDR_W-1:0] REG_STATE  = 4'h7;

  // status bit positions; time-out and power-down read as active-low flags
  localparam int SB_C   = 0;
  localparam int SB_NC  = 1;
  localparam int SB_Z   = 2;
  localparam int SB_PWD = 3;
  localparam int SB_TMO = 4;

  localparam logic [STAT_W-1:0] STATUS_RST = 5'h18;
  localparam logic [BYTE_W-1:0] ACC_RST    = 8'h00;
  localparam logic [PC_W-1:0]   PC_RST     = 15'h0000;
  localparam logic [PC_W-1:0]   PC_STEP    = 15'h0001;

  typedef enum logic [2:0] {
    OP_NOP    = 3'h0,
    OP_RETURN = 3'h1,
    OP_ROTL   = 3'h2,
    OP_ROTR   = 3'h3,
    OP_SLEEP  = 3'h4,
    OP_SUB    = 3'h5
  } cise_op_t;

  typedef enum logic [2:0] {
    ST_IDLE    = 3'h1,
    ST_EXEC    = 3'h2,
    ST_REFETCH = 3'h4
  } cise_state_t;

  typedef struct packed {
    logic [4:0]         pad;
    cise_op_t           op;
    logic               dest;
    logic [FILE_AW-1:0] faddr;
  } cise_instr_t;

  typedef struct packed {
    logic [BYTE_W-1:0] res;
    logic              c;
    logic              nc;
    logic              z;
  } cise_alu_t;

  typedef struct packed {
    logic              wr;
    logic              rd;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
  } cise_bus_t;

endpackage : cise_pkg
